// >>> src/aps_regs.svh
// register offsets, field positions, reset values and timing counts of the protection sequencer
`ifndef APS_REGS_SVH
`define APS_REGS_SVH

`define APS_CTRL_OFS 12'h000
`define APS_STAT_OFS 12'h004

`define APS_CTRL_MUTE_BIT 0
`define APS_CTRL_SLEEP_BIT 1
`define APS_CTRL_RST 32'h0000_0000

`define APS_STAT_SLEEP_BIT 0
`define APS_STAT_RUN_BIT 1
`define APS_STAT_FAULT_BIT 2
`define APS_STAT_OTEMP_BIT 3
`define APS_STAT_DRIVE_BIT 4
`define APS_STAT_ROLE_BIT 5
`define APS_STAT_BIAS_BIT 6

`define APS_CLK_PERIOD_NS 50
`define APS_DELAY_US 16400
`define APS_DELAY_CYCLES ((`APS_DELAY_US * 1000 + `APS_CLK_PERIOD_NS - 1) / `APS_CLK_PERIOD_NS)
`define APS_OSC_HALF 40

`endif

// >>> src/aps_pkg.sv
// types shared by the protection sequencer files
`default_nettype none
package aps_pkg;
   typedef enum logic [1:0] {
      APS_SLEEP,
      APS_BIAS_WAIT,
      APS_DELAY,
      APS_RUN
   } aps_state_e;
endpackage
`default_nettype wire

// >>> src/aps_delay_timer.sv
// start-up delay timer: counts while enabled, flags expiry
`timescale 1ns/1ps
`default_nettype none
module aps_delay_timer #(
   parameter int CYCLES = 328000
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   output logic done_q
);
   localparam int CW = $clog2(CYCLES + 1);
   logic [CW-1:0] cnt_q;

   // dropping run restarts the count from zero, so each wake gets the full wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         done_q <= 1'b0;
      end else if (!run) begin
         cnt_q <= '0;
         done_q <= 1'b0;
      end else if (cnt_q == CW'(CYCLES - 1)) begin
         done_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   timer_full_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(done_q) |-> $past(run) && $past(cnt_q) == CW'(CYCLES - 1))
      else $error("delay timer expired early");
endmodule
`default_nettype wire

// >>> src/aps_protection_sequencer.sv
// control and protection sequencer of a mono switching amplifier, with apb registers
//
// Operation
// - after bias ready, wait 16.4 ms, then allow output switching
// - power-up and every wake from sleep run the same bias and delay sequence
// - sleep input low silences outputs and holds the low-current state
// - mute high disables outputs, mute low enables them
// - detected output short cuts drive at once
// - short fault latches; cleared only by cycling sleep or mute
// - fault output high while short flag set, low once cleared
// - mute high clears short flag; run resumes when mute low
// - role select high: internal oscillator, driven out on sync pin
// - role select low: sync pin is input, switching follows it
// - over-temperature forces sleep and output off, not latched
// - over-temperature clears after cooling, operation resumes by itself
`timescale 1ns/1ps
`default_nettype none
`include "aps_regs.svh"
module aps_protection_sequencer
   import aps_pkg::*;
#(
   parameter int DELAY_CYCLES = `APS_DELAY_CYCLES,
   parameter int OSC_HALF = `APS_OSC_HALF,
   parameter int AW = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleep_n,
   input wire logic mute,
   input wire logic bias_ready,
   input wire logic short_detect,
   input wire logic over_temp,
   input wire logic role_select,
   input wire logic sync_in,
   output logic sync_out,
   output logic sync_oe,
   output logic pwm_clk,
   output logic drive_en,
   output logic fault,
   output logic low_power
);
   aps_state_e state_q, state_d;
   logic [31:0] ctrl_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q;
   logic drive_en_q, fault_q, low_power_q;
   logic sync_out_q, sync_oe_q, pwm_clk_q, osc_q;
   logic [15:0] osc_cnt_q;
   logic osc_tick;
   logic timer_done;
   logic mute_eff, sleep_eff, short_set;
   logic setup, access, hit_ctrl, hit_stat;
   logic [31:0] stat_w;

   // monitors come in already synchronous, so they are used without extra stages
   assign mute_eff = mute | ctrl_q[`APS_CTRL_MUTE_BIT];
   assign sleep_eff = ~sleep_n | ctrl_q[`APS_CTRL_SLEEP_BIT] | over_temp;
   // a short counts whenever the bridge would be driven, so a short that outlives a mute
   // cycle trips again instead of leaving drive off with the flag clear
   assign short_set = short_detect & (state_q == APS_RUN) & ~mute_eff & ~sleep_eff;

   // apb slave
   assign setup = psel & ~penable;
   assign access = psel & penable & pready_q;
   assign hit_ctrl = (paddr == `APS_CTRL_OFS);
   assign hit_stat = (paddr == `APS_STAT_OFS);

   always_comb begin
      stat_w = 32'h0000_0000;
      stat_w[`APS_STAT_SLEEP_BIT] = (state_q == APS_SLEEP);
      stat_w[`APS_STAT_RUN_BIT] = (state_q == APS_RUN);
      stat_w[`APS_STAT_FAULT_BIT] = fault_q;
      stat_w[`APS_STAT_OTEMP_BIT] = over_temp;
      stat_w[`APS_STAT_DRIVE_BIT] = drive_en_q;
      stat_w[`APS_STAT_ROLE_BIT] = role_select;
      stat_w[`APS_STAT_BIAS_BIT] = bias_ready;
   end

   // zero-wait slave: ready rises for the access cycle that follows every setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup & ~(hit_ctrl | (hit_stat & ~pwrite));
         if (setup && !pwrite && hit_ctrl) begin
            prdata_q <= ctrl_q;
         end else if (setup && !pwrite && hit_stat) begin
            prdata_q <= stat_w;
         end else if (setup) begin
            prdata_q <= 32'h0000_0000;
         end
      end
   end

   // only the low byte holds control bits; upper lanes are ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `APS_CTRL_RST;
      end else if (access && pwrite && hit_ctrl && pstrb[0]) begin
         ctrl_q <= {30'h0000_0000, pwdata[1:0]};
      end
   end

   // power sequencing
   always_comb begin
      state_d = state_q;
      case (state_q)
         APS_SLEEP: begin
            if (!sleep_eff) begin
               state_d = APS_BIAS_WAIT;
            end
         end
         APS_BIAS_WAIT: begin
            if (sleep_eff) begin
               state_d = APS_SLEEP;
            end else if (bias_ready) begin
               state_d = APS_DELAY;
            end
         end
         APS_DELAY: begin
            if (sleep_eff) begin
               state_d = APS_SLEEP;
            end else if (timer_done) begin
               state_d = APS_RUN;
            end
         end
         APS_RUN: begin
            if (sleep_eff) begin
               state_d = APS_SLEEP;
            end
         end
         default: begin
            state_d = APS_SLEEP;
         end
      endcase
   end

   // power-up enters the same bias wait as a wake from sleep
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= APS_BIAS_WAIT;
      end else begin
         state_q <= state_d;
      end
   end

   // the timer restarts whenever the sequencer leaves the delay state
   aps_delay_timer #(
      .CYCLES(DELAY_CYCLES)
   ) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .run(state_q == APS_DELAY),
      .done_q(timer_done)
   );

   // registered from the next state so the pin matches the sleep state in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_power_q <= 1'b0;
      end else begin
         low_power_q <= (state_d == APS_SLEEP);
      end
   end

   // output drive and short fault
   // the raw short input also gates drive so the bridge drops on the detecting edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_en_q <= 1'b0;
      end else begin
         drive_en_q <= (state_q == APS_RUN) & ~sleep_eff & ~mute_eff
                       & ~short_detect & ~fault_q;
      end
   end

   // set wins over clear; clearing is level-held for as long as mute or sleep stays on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_q <= 1'b0;
      end else if (short_set) begin
         fault_q <= 1'b1;
      end else if (mute_eff || sleep_eff) begin
         fault_q <= 1'b0;
      end
   end

   // switching clock and sync pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_cnt_q <= 16'h0000;
      end else if (osc_tick) begin
         osc_cnt_q <= 16'h0000;
      end else begin
         osc_cnt_q <= osc_cnt_q + 16'h0001;
      end
   end
   assign osc_tick = (osc_cnt_q == 16'(OSC_HALF - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_q <= 1'b0;
      end else if (osc_tick) begin
         osc_q <= ~osc_q;
      end
   end

   // slave mode follows the incoming edges one clock late; jitter is one pclk period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_oe_q <= 1'b0;
         sync_out_q <= 1'b0;
         pwm_clk_q <= 1'b0;
      end else begin
         sync_oe_q <= role_select;
         sync_out_q <= role_select & osc_q;
         pwm_clk_q <= role_select ? osc_q : sync_in;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign sync_out = sync_out_q;
   assign sync_oe = sync_oe_q;
   assign pwm_clk = pwm_clk_q;
   assign drive_en = drive_en_q;
   assign fault = fault_q;
   assign low_power = low_power_q;

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   drive_gate_a: assert property (drive_en_q |-> $past(state_q) == APS_RUN)
      else $error("drive enabled outside run");
   wake_seq_a: assert property (state_q == APS_SLEEP && !sleep_eff |=> state_q == APS_BIAS_WAIT)
      else $error("wake skipped bias wait");
   sleep_off_a: assert property (!sleep_n |=> !drive_en_q && low_power_q)
      else $error("sleep did not silence outputs");
   mute_off_a: assert property (mute_eff |=> !drive_en_q)
      else $error("mute did not disable outputs");
   short_cut_a: assert property (short_detect && drive_en_q |=> !drive_en_q ##1 !drive_en_q)
      else $error("short did not cut drive");
   fault_hold_a: assert property (fault_q && !mute_eff && !sleep_eff |=> fault_q)
      else $error("fault cleared without cycling");
   fault_out_a: assert property (short_set |=> fault && fault_q)
      else $error("fault output missed short");
   mute_clear_a: assert property (fault_q && mute_eff && !short_set |=> !fault)
      else $error("mute did not clear fault");
   master_drive_a: assert property (role_select |=> sync_oe_q && sync_out_q == $past(osc_q))
      else $error("master not driving sync");
   slave_follow_a: assert property (!role_select |=> !sync_oe_q && pwm_clk_q == $past(sync_in))
      else $error("slave not following sync");
   otemp_sleep_a: assert property (over_temp |=> state_q == APS_SLEEP && !drive_en_q)
      else $error("over-temperature did not sleep");
   otemp_resume_a: assert property (state_q == APS_SLEEP && !over_temp && sleep_n
      && ctrl_q[`APS_CTRL_SLEEP_BIT] == 1'b0 |=> state_q == APS_BIAS_WAIT)
      else $error("no resume after cooling");
   // the slave answers in the cycle after setup and never holds ready for two cycles
   ready_once_a: assert property (setup |=> pready_q ##1 !pready_q)
      else $error("ready not a single access pulse");
   stat_ro_a: assert property (access && pwrite && !hit_ctrl |=> $stable(ctrl_q))
      else $error("refused write changed control");
   run_hold_a: assert property (state_q != APS_RUN && !timer_done |=> state_q != APS_RUN)
      else $error("run entered before delay expiry");
   short_retrip_a: assert property (fault_q && mute_eff && short_detect ##1 state_q == APS_RUN
      && !mute_eff && !sleep_eff && short_detect |=> fault_q)
      else $error("persisting short did not trip again");
   fault_quiet_a: assert property (!fault_q && !short_set |=> !fault_q)
      else $error("fault raised without a short");

   run_reached_c: cover property (state_q == APS_DELAY ##1 state_q == APS_RUN);
   auto_recover_c: cover property (fault_q ##[1:4] !fault_q ##[1:8] drive_en_q);
   slave_mode_c: cover property (!role_select && $rose(pwm_clk_q));
   otemp_trip_c: cover property (state_q == APS_RUN && over_temp);
   // the retrip cover needs the fault output looped back to mute
   short_retrip_c: cover property (fault_q ##1 !fault_q ##1 fault_q);
endmodule
`default_nettype wire

// >>> testbench/aps_host_model.sv
// host gpio and companion amplifier model: mute wiring and slave sync source
`timescale 1ns/1ps
`default_nettype none
module aps_host_model #(
   parameter int SYNC_HALF = 40
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ext_mute,
   input wire logic loop_en,
   input wire logic fault,
   output logic mute,
   output logic sync_in
);
   int cnt_q;
   logic sync_q;
   // mute is never left floating; fault is ored in for auto recovery
   assign mute = ext_mute | (loop_en & fault);
   assign sync_in = sync_q;
   // free-running square wave; half period shortened in simulation to keep runs short
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 0;
         sync_q <= 1'b0;
      end else if (cnt_q == SYNC_HALF - 1) begin
         cnt_q <= 0;
         sync_q <= ~sync_q;
      end else begin
         cnt_q <= cnt_q + 1;
      end
   end
endmodule
`default_nettype wire

// >>> testbench/test_aps_protection_sequencer.sv
// self-checking bench of the amplifier protection sequencer
`timescale 1ns/1ps
`default_nettype none
`include "aps_regs.svh"
module test_aps_protection_sequencer import aps_pkg::*;;
   localparam int DLY = 20;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   logic [15:0] lfsr_q = 16'd54892;
   logic sleep_n = 1'b1, ext_mute = 1'b0, loop_en = 1'b0, bias_ready = 1'b0, short_detect = 1'b0;
   logic over_temp = 1'b0, role_select = 1'b0, pready, pslverr, err, prev;
   logic mute, sync_in, sync_out, sync_oe, pwm_clk, drive_en, fault, low_power;
   int fails = 0, checked = 0, n;

   aps_protection_sequencer #(.DELAY_CYCLES(DLY), .OSC_HALF(2)) dut_u (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .sleep_n, .mute, .bias_ready,
      .short_detect, .over_temp, .role_select, .sync_in, .sync_out, .sync_oe, .pwm_clk, .drive_en,
      .fault, .low_power);
   aps_host_model #(.SYNC_HALF(3)) host_u (.pclk, .presetn, .ext_mute, .loop_en, .fault, .mute, .sync_in);

   initial begin
      forever #25 pclk = ~pclk;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic print_verdict();
      if (fails == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(negedge pclk);
   endtask

   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // counts cycles until switching starts; never earlier than the full delay
   task automatic wait_run(input int lim);
      n = 0;
      while (drive_en !== 1'b1 && n < 200) begin
         @(negedge pclk);
         n++;
      end
      chk("start_delay", 32'(n >= DLY && n <= lim), 32'h1);
   endtask

   task automatic set_short(input logic s);
      @(posedge pclk);
      short_detect <= s;
   endtask

   initial begin
      cyc(8);
      @(posedge pclk);
      presetn <= 1'b1;
      cyc(30);
      chk("drive_no_bias", 32'(drive_en), 32'h0);
      @(posedge pclk);
      bias_ready <= 1'b1;
      wait_run(DLY + 6);
      @(posedge pclk);
      ext_mute <= 1'b1;
      cyc(2);
      chk("drive_muted", 32'(drive_en), 32'h0);
      @(posedge pclk);
      ext_mute <= 1'b0;
      cyc(3);
      chk("drive_unmuted", 32'(drive_en), 32'h1);
      for (int i = 0; i < 3; i++) begin
         lfsr_q = lfsr(lfsr_q);
         apb(1'b1, `APS_CTRL_OFS, {lfsr_q, lfsr_q} & 32'hffff_fffd);
         apb(1'b0, `APS_CTRL_OFS, 32'h0);
         chk("ctrl_read", rd, {31'h0, lfsr_q[0]});
         cyc(1);
         chk("soft_mute", 32'(drive_en), 32'(!lfsr_q[0]));
      end
      apb(1'b1, `APS_CTRL_OFS, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped_err", {31'h0, err}, 32'h1);
      chk("unmapped_data", rd, 32'h0);
      apb(1'b1, `APS_STAT_OFS, 32'hffff_ffff);
      chk("status_write_err", {31'h0, err}, 32'h1);
      cyc(4);
      repeat (lfsr_q[2:0]) @(posedge pclk);
      set_short(1'b1);
      set_short(1'b0);
      cyc(1);
      chk("short_cut", 32'(drive_en), 32'h0);
      chk("fault_set", 32'(fault), 32'h1);
      cyc(10);
      chk("fault_latched", 32'(fault), 32'h1);
      apb(1'b0, `APS_STAT_OFS, 32'h0);
      chk("status_fault", 32'(rd[`APS_STAT_FAULT_BIT]), 32'h1);
      @(posedge pclk);
      ext_mute <= 1'b1;
      @(posedge pclk);
      ext_mute <= 1'b0;
      cyc(2);
      chk("fault_cleared", 32'(fault), 32'h0);
      cyc(3);
      chk("drive_resumed", 32'(drive_en), 32'h1);
      @(posedge pclk);
      loop_en <= 1'b1;
      set_short(1'b1);
      n = 0;
      repeat (40) begin
         prev = fault;
         @(negedge pclk);
         if (fault === 1'b1 && prev === 1'b0) n++;
      end
      chk("fault_retrips", 32'(n >= 2), 32'h1);
      set_short(1'b0);
      cyc(10);
      chk("auto_recovered", {30'h0, fault, drive_en}, 32'h1);
      @(posedge pclk);
      loop_en <= 1'b0;
      sleep_n <= 1'b0;
      bias_ready <= 1'b0;
      cyc(3);
      chk("sleep_entered", {30'h0, low_power, drive_en}, 32'h2);
      cyc(20);
      chk("sleep_held", {30'h0, low_power, drive_en}, 32'h2);
      @(posedge pclk);
      sleep_n <= 1'b1;
      cyc(10);
      chk("wake_waits_bias", 32'(drive_en), 32'h0);
      @(posedge pclk);
      bias_ready <= 1'b1;
      wait_run(DLY + 8);
      @(posedge pclk);
      over_temp <= 1'b1;
      cyc(3);
      chk("hot_shutdown", {30'h0, low_power, drive_en}, 32'h2);
      @(posedge pclk);
      over_temp <= 1'b0;
      wait_run(DLY + 8);
      @(posedge pclk);
      role_select <= 1'b1;
      cyc(3);
      chk("master_oe", 32'(sync_oe), 32'h1);
      n = 0;
      repeat (16) begin
         prev = sync_out;
         @(negedge pclk);
         if (sync_out !== prev) n++;
      end
      chk("osc_toggles", n, 32'h8);
      @(posedge pclk);
      role_select <= 1'b0;
      cyc(3);
      chk("slave_pin", {30'h0, sync_oe, sync_out}, 32'h0);
      repeat (12) begin
         prev = sync_in;
         @(negedge pclk);
         chk("pwm_follows_sync", 32'(pwm_clk), 32'(prev));
      end
      @(posedge pclk);
      ext_mute <= 1'b1;
      cyc(2);
      chk("drive_off_at_end", 32'(drive_en), 32'h0);
      print_verdict();
   end

   // the whole sequence needs well under 1000 cycles
   initial begin
      repeat (5000) @(posedge pclk);
      fails++;
      print_verdict();
   end
endmodule
`default_nettype wire
